// ==== verilog/mie_defs.vh ====
/*
 * Constants for the instruction subset executor: opcode patterns,
 * field positions, register offsets and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH

// Instruction word fields
`define MIE_IW 14
`define MIE_DEST_BIT 7
`define MIE_FADDR_W 7

// Opcode patterns (upper six bits, fewer for the HI forms, low byte for the misc words)
`define MIE_OP_ADDLIT_HI 5'h1F
`define MIE_OP_ANDLIT 6'h39
`define MIE_OP_RETLIT_HI 4'hD
`define MIE_OP_ANDFILE 6'h05
`define MIE_OP_ADDFILE 6'h07
`define MIE_OP_ROTL 6'h0D
`define MIE_OP_MISC 6'h00
`define MIE_OP_OPTLOAD 8'h62
`define MIE_OP_RETURN 8'h08
`define MIE_OP_RETIRQ 8'h09

// Register port offsets
`define MIE_REG_ACC 2'h0
`define MIE_REG_STATUS 2'h1
`define MIE_REG_OPTION 2'h2
`define MIE_REG_PC 2'h3

// Status bit positions
`define MIE_ST_CARRY 0
`define MIE_ST_NIBBLE 1
`define MIE_ST_ZERO 2
`define MIE_ST_GIE 3

// Reset values
`define MIE_OPTION_RST 8'hFF
`define MIE_PC_RST 13'h0000

// Cycles for two-cycle instructions
`define MIE_RET_CYCLES 2'h2

`endif

// ==== verilog/mie_alu.v ====
/*
 * Arithmetic and logic unit for the subset executor.
 * Purely combinational; the caller registers results and flags.
 */
`timescale 1ns/1ps
`include "mie_defs.vh"

module mie_alu (
  input wire [1:0] i_op,
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_carry,
  output reg [7:0] o_res,
  output reg o_carry,
  output reg o_nibble,
  output reg o_zero
);
  reg [8:0] sum;
  reg [4:0] low;

  // Op 0 add, 1 and, 2 rotate left of i_b, 3 pass i_a
  always @* begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    o_carry = i_carry;
    o_nibble = low[4];
    case (i_op)
      2'h0: begin
        o_res = sum[7:0];
        o_carry = sum[8];
      end
      2'h1: o_res = i_a & i_b;
      2'h2: begin
        o_res = {i_b[6:0], i_carry};
        o_carry = i_b[7];
      end
      default: o_res = i_a;
    endcase
    o_zero = (o_res == 8'h00);
  end
endmodule

// ==== verilog/mie_core.v ====
/*
 * Executes a subset of a 14-bit instruction set: add, and, move,
 * rotate, option load, no-op and the three returns.
 * Assumes the program memory presents one word with a valid strobe,
 * file registers answer reads combinationally on i_file_rdata, and
 * the stack top arrives on i_stack_top.
 */
`timescale 1ns/1ps
`include "mie_defs.vh"

// Summary of operation
// - Add immediate to accumulator, set C DC Z
// - And immediate with accumulator, set Z only
// - And accumulator with file, set Z only
// - Destination bit selects accumulator or file
// - Add accumulator to file, set C DC Z
// - Copy accumulator to file, flags unchanged
// - Option load copies accumulator, flags unchanged
// - Return with immediate, pop stack, two cycles
// - Plain return pops stack, two cycles
// - Rotate file left through carry, routed
module mie_core (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_instr_valid,
  input wire [13:0] i_instr,
  input wire [7:0] i_file_rdata,
  input wire [12:0] i_stack_top,
  input wire [1:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg o_busy,
  output reg [6:0] o_file_addr,
  output reg o_file_wr,
  output reg [7:0] o_file_wdata,
  output reg o_stack_pop,
  output reg [12:0] o_pc,
  output reg [7:0] o_acc,
  output reg o_carry,
  output reg o_nibble_overflow_bit,
  output reg o_zero,
  output reg o_global_irq_enable,
  output reg [7:0] o_option,
  output reg [7:0] o_reg_rdata
);
  // Two states suffice: returns are the only two-cycle words.
  // The second cycle is a dead slot while the fetch refills,
  // so nothing is decoded there and the presented word waits.
  localparam ST_RUN = 1'b0;
  localparam ST_POP = 1'b1;

  reg state;
  reg [1:0] alu_op;
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire dest_file;
  wire [5:0] hi6;

  assign hi6 = i_instr[13:8];
  assign dest_file = i_instr[`MIE_DEST_BIT];

  // Decode classes
  // Literal forms are matched first because their top bits are set
  // and can never alias a file-register form.
  // The misc group (top six bits zero) is split on the low byte.
  // Every word outside the subset falls to class 0 and behaves as a
  // no-op, so unknown code cannot corrupt state.
  function [3:0] mie_class;
    input [13:0] w;
    begin
      if (w[13:9] == `MIE_OP_ADDLIT_HI)
        mie_class = 4'h1;
      else if (w[13:8] == `MIE_OP_ANDLIT)
        mie_class = 4'h2;
      else if (w[13:10] == `MIE_OP_RETLIT_HI)
        mie_class = 4'h3;
      else if (w[13:8] == `MIE_OP_ANDFILE)
        mie_class = 4'h4;
      else if (w[13:8] == `MIE_OP_ADDFILE)
        mie_class = 4'h5;
      else if (w[13:8] == `MIE_OP_ROTL)
        mie_class = 4'h6;
      else if (w[13:8] == `MIE_OP_MISC && w[7])
        mie_class = 4'h7;
      else if (w[13:8] == `MIE_OP_MISC && w[7:0] == `MIE_OP_OPTLOAD)
        mie_class = 4'h8;
      else if (w[13:8] == `MIE_OP_MISC && w[7:0] == `MIE_OP_RETURN)
        mie_class = 4'h9;
      else if (w[13:8] == `MIE_OP_MISC && w[7:0] == `MIE_OP_RETIRQ)
        mie_class = 4'hA;
      else
        mie_class = 4'h0; // No-op and anything outside the subset
    end
  endfunction

  wire [3:0] cls;
  assign cls = mie_class(i_instr);

  // ALU operand selection
  // Operand A is always the accumulator; operand B is the literal
  // for immediate forms and the addressed file value otherwise.
  // The file value is combinational, so its address must be stable
  // for the whole cycle in which the word is presented.
  always @* begin
    alu_a = o_acc;
    alu_b = i_file_rdata;
    case (cls)
      4'h1: begin
        alu_op = 2'h0;
        alu_b = i_instr[7:0];
      end
      4'h2: begin
        alu_op = 2'h1;
        alu_b = i_instr[7:0];
      end
      4'h4: alu_op = 2'h1;
      4'h5: alu_op = 2'h0;
      4'h6: alu_op = 2'h2;
      default: alu_op = 2'h3;
    endcase
  end

  mie_alu u_alu (
    .i_op(alu_op),
    .i_a(alu_a),
    .i_b(alu_b),
    .i_carry(o_carry),
    .o_res(alu_res),
    .o_carry(alu_c),
    .o_nibble(alu_dc),
    .o_zero(alu_z)
  );

  // Execute; software register writes lose to instruction effects
  // The register write is evaluated first and the instruction later
  // in the same process, so the later assignment wins on a clash.
  // Strobes are cleared each cycle and set only for one edge.
  // Limitation: the stack depth lives outside; an empty stack is
  // not detected here and the popped value is taken as given.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RUN;
      o_busy <= 1'b0;
      o_file_addr <= 7'h00;
      o_file_wr <= 1'b0;
      o_file_wdata <= 8'h00;
      o_stack_pop <= 1'b0;
      o_pc <= `MIE_PC_RST;
      o_acc <= 8'h00;
      o_carry <= 1'b0;
      o_nibble_overflow_bit <= 1'b0;
      o_zero <= 1'b0;
      o_global_irq_enable <= 1'b0;
      o_option <= `MIE_OPTION_RST;
    end else begin
      o_file_wr <= 1'b0;
      o_stack_pop <= 1'b0;
      if (i_reg_wr) begin
        case (i_reg_addr)
          `MIE_REG_ACC: o_acc <= i_reg_wdata;
          `MIE_REG_STATUS: begin
            o_carry <= i_reg_wdata[`MIE_ST_CARRY];
            o_nibble_overflow_bit <= i_reg_wdata[`MIE_ST_NIBBLE];
            o_zero <= i_reg_wdata[`MIE_ST_ZERO];
            o_global_irq_enable <= i_reg_wdata[`MIE_ST_GIE];
          end
          `MIE_REG_OPTION: o_option <= i_reg_wdata;
          default: o_pc <= {5'h00, i_reg_wdata};
        endcase
      end
      case (state)
        ST_POP: begin
          // Second cycle of a return: the dummy cycle
          // The valid input is ignored here; the source must hold its
          // word until busy drops, or the word is lost.
          state <= ST_RUN;
          o_busy <= 1'b0;
        end
        default: begin
          if (i_instr_valid) begin
            o_pc <= o_pc + 13'h0001;
            o_file_addr <= i_instr[6:0];
            case (cls)
              4'h1: begin
                o_acc <= alu_res;
                o_carry <= alu_c;
                o_nibble_overflow_bit <= alu_dc;
                o_zero <= alu_z;
              end
              4'h2: begin
                o_acc <= alu_res;
                o_zero <= alu_z;
              end
              4'h3: begin
                o_acc <= i_instr[7:0];
                o_pc <= i_stack_top;
                o_stack_pop <= 1'b1;
                o_busy <= 1'b1;
                state <= ST_POP;
              end
              4'h4: begin
                o_zero <= alu_z;
                if (dest_file) begin
                  o_file_wr <= 1'b1;
                  o_file_wdata <= alu_res;
                end else
                  o_acc <= alu_res;
              end
              4'h5: begin
                o_carry <= alu_c;
                o_nibble_overflow_bit <= alu_dc;
                o_zero <= alu_z;
                if (dest_file) begin
                  o_file_wr <= 1'b1;
                  o_file_wdata <= alu_res;
                end else
                  o_acc <= alu_res;
              end
              4'h6: begin
                o_carry <= alu_c;
                if (dest_file) begin
                  o_file_wr <= 1'b1;
                  o_file_wdata <= alu_res;
                end else
                  o_acc <= alu_res;
              end
              4'h7: begin
                o_file_wr <= 1'b1;
                o_file_wdata <= o_acc;
              end
              // legacy option load
              // Kept for old code only; flags are left alone.
              4'h8: begin
                o_option <= o_acc;
              end
              4'h9: begin
                o_pc <= i_stack_top;
                o_stack_pop <= 1'b1;
                o_busy <= 1'b1;
                state <= ST_POP;
              end
              // pop and enable irq
              // Enable is set on the pop edge, so an interrupt could
              // be taken straight after the dead cycle.
              4'hA: begin
                o_pc <= i_stack_top;
                o_global_irq_enable <= 1'b1;
                o_stack_pop <= 1'b1;
                o_busy <= 1'b1;
                state <= ST_POP;
              end
              // no state change
              // Address is held so a no-op leaves no visible trace
              // beyond the counter step.
              default: begin
                o_file_addr <= o_file_addr;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Register read port, data one cycle after strobe
  // Data shows only in the cycle after the strobe and is zero
  // otherwise, so a stale value is never mistaken for a reply.
  // A read in the same cycle as an instruction returns the value
  // from before that instruction took effect.
  // Only the low byte of the counter is visible to software.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd) begin
      case (i_reg_addr)
        `MIE_REG_ACC: o_reg_rdata <= o_acc;
        `MIE_REG_STATUS: o_reg_rdata <= {4'h0, o_global_irq_enable,
          o_zero, o_nibble_overflow_bit, o_carry};
        `MIE_REG_OPTION: o_reg_rdata <= o_option;
        default: o_reg_rdata <= o_pc[7:0];
      endcase
    end else
      o_reg_rdata <= 8'h00;
  end
endmodule

// ==== test/mie_core_sva.sv ====
/* Checker on the core's ports.
   Assumes it is bound to every core instance. */
`timescale 1ns/1ps
module mie_core_sva (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_instr_valid,
  input wire [13:0] i_instr,
  input wire [7:0] i_file_rdata,
  input wire [12:0] i_stack_top,
  input wire o_busy,
  input wire [6:0] o_file_addr,
  input wire o_file_wr,
  input wire [7:0] o_file_wdata,
  input wire o_stack_pop,
  input wire [12:0] o_pc,
  input wire [7:0] o_acc,
  input wire o_carry,
  input wire o_zero,
  input wire o_global_irq_enable,
  input wire [7:0] o_option
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Word taken this edge; the busy cycle refuses
  wire tk = i_instr_valid & ~o_busy;
  wire [6:0] op = i_instr[13:7];
  a_ret_pop: assert property (tk && (op[6:3] == 4'hD ||
    i_instr[13:1] == 13'h0004) |=> o_stack_pop && o_busy &&
    o_pc == $past(i_stack_top) ##1 !o_busy) else $error("bad return");
  a_move_write: assert property (tk && op == 7'h01 |=> o_file_wr &&
    o_file_wdata == $past(o_acc) && o_file_addr == $past(i_instr[6:0]))
    else $error("bad move");
  a_add_sum: assert property (tk && op[6:2] == 5'h1F |=>
    {o_carry, o_acc} == {1'b0, $past(o_acc)} + {1'b0, $past(i_instr[7:0])})
    else $error("bad add");
  a_and_zero: assert property (tk && op[6:1] == 6'h39 |=>
    o_acc == ($past(o_acc) & $past(i_instr[7:0])) &&
    o_zero == (o_acc == 8'h00) && $stable(o_carry)) else $error("bad and");
  a_irq_ret: assert property (tk && i_instr == 14'h0009 |=>
    o_global_irq_enable [*2]) else $error("bad irq return");
  a_nop_idle: assert property (tk && i_instr == 14'h0000 |=>
    !o_file_wr && $stable(o_acc) && o_pc == $past(o_pc) + 13'h0001)
    else $error("bad nop");
  a_opt_load: assert property (tk && i_instr == 14'h0062 |=>
    o_option == $past(o_acc)) else $error("bad option load");
  a_rot_carry: assert property (tk && op == 7'h1A |=>
    o_acc == {$past(i_file_rdata[6:0]), $past(o_carry)} &&
    o_carry == $past(i_file_rdata[7])) else $error("bad rotate");
endmodule

bind mie_core mie_core_sva i_sva (.*);

// ==== test/mie_pmem_model.sv ====
/* Program memory model: presents stored words in order.
   Assumes the bench fills mem and n, then pulses i_start. */
`timescale 1ns/1ps
module mie_pmem_model (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_start,
  input wire i_slow,
  input wire i_busy,
  output wire o_instr_valid,
  output wire [13:0] o_instr,
  output wire o_done
);
  reg [13:0] mem [0:63];
  reg [6:0] n = 7'h00;
  reg [6:0] ptr;
  reg gap;
  assign o_done = ptr >= n;
  assign o_instr_valid = ~o_done & ~gap;
  // Idle bus shows junk, never a stale word
  assign o_instr = o_instr_valid ? mem[ptr[5:0]] : {ptr, ~ptr};
  // A word holds until taken; slow mode idles a cycle after each
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr <= 7'h40;
      gap <= 1'b0;
    end else if (i_start) begin
      ptr <= 7'h00;
      gap <= 1'b0;
    end else begin
      gap <= o_instr_valid & ~i_busy & i_slow;
      if (o_instr_valid && !i_busy) ptr <= ptr + 7'h01;
    end
  end
endmodule

// ==== test/tb.sv ====
/* Self-checking bench for the core with random programs.
   Assumes the program memory model and the bound checker. */
`timescale 1ns/1ps
module tb;
  reg i_ref_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [1:0] i_reg_addr = 2'h0;
  reg [7:0] i_reg_wdata = 8'h00;
  reg i_reg_wr = 1'b0;
  reg i_reg_rd = 1'b0;
  reg [12:0] i_stack_top = 13'h0000;
  reg start = 1'b0;
  reg slow = 1'b0;
  reg took = 1'b0;
  wire vld, busy, fwr, pop, c, dc, z, global_irq_enable, done;
  wire [13:0] ins;
  wire [6:0] fa;
  wire [7:0] fwd, acc, opt, rdat;
  wire [12:0] pc;
  reg [7:0] fm [0:127];
  reg [7:0] a_r, o_r, d, b;
  reg [3:0] f_r;
  reg [12:0] p_r;
  reg [8:0] s;
  reg [4:0] h;
  reg [1:0] dst;
  reg [13:0] w;
  reg [23:0] e;
  reg [42:0] q [$];
  reg [31:0] rnd = 32'h1BAD;
  integer errors = 0, comparisons = 0, k, p;
  // Word kinds: base pattern and mask of free bits
  localparam [263:0] KT = {24'hF801FF, 24'hE400FF, 24'hD003FF, 24'h1400FF,
    24'h1C00FF, 24'h02007F, 24'h3400FF, 24'h018800, 24'h002000,
    24'h002400, 24'h018060};
  mie_core i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_instr_valid(vld), .i_instr(ins), .i_file_rdata(fm[ins[6:0]]),
    .i_stack_top(i_stack_top), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_busy(busy), .o_file_addr(fa), .o_file_wr(fwr), .o_file_wdata(fwd),
    .o_stack_pop(pop), .o_pc(pc), .o_acc(acc), .o_carry(c),
    .o_nibble_overflow_bit(dc), .o_zero(z), .o_global_irq_enable(global_irq_enable),
    .o_option(opt), .o_reg_rdata(rdat));
  mie_pmem_model i_pm (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_start(start), .i_slow(slow), .i_busy(busy), .o_instr_valid(vld),
    .o_instr(ins), .o_done(done));
  always #2.5 i_ref_clk = ~i_ref_clk;
  // Stack top wanders so each return sees a fresh value
  always @(posedge i_ref_clk) i_stack_top <= i_stack_top * 13'h00B5 + 13'h3;
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task bus(input [1:0] ad, input [7:0] v, input wr);
    begin
      @(posedge i_ref_clk);
      i_reg_addr <= ad;
      i_reg_wdata <= v;
      i_reg_wr <= wr;
      i_reg_rd <= ~wr;
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      @(negedge i_ref_clk);
      if (!wr) chk(rdat, v);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Reference model: predicts each taken word, notes the result
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      a_r = 8'h00;
      f_r = 4'h0;
      p_r = 13'h0000;
      o_r = 8'hFF;
      took <= 1'b0;
      q.delete();
    end else begin
      took <= vld & ~busy;
      if (i_reg_wr && i_reg_addr == 2'h0) a_r = i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 2'h3) p_r = {5'h00, i_reg_wdata};
      if (i_reg_wr && i_reg_addr == 2'h1) f_r = i_reg_wdata[3:0];
      if (i_reg_wr && i_reg_addr == 2'h2) o_r = i_reg_wdata;
      if (vld && !busy) begin
        w = ins;
        dst = 2'h2;
        d = 8'h00;
        b = w[13] ? w[7:0] : fm[w[6:0]];
        s = a_r + b;
        h = a_r[3:0] + b[3:0];
        p_r = p_r + 13'h0001;
        casez (w)
          14'b11_111?_????_????, 14'b00_0111_????_????: begin
            d = s[7:0];
            f_r[2:0] = {d == 8'h00, h[4], s[8]};
            dst = {1'b0, ~w[13] & w[7]};
          end
          14'b11_1001_????_????, 14'b00_0101_????_????: begin
            d = a_r & b;
            f_r[2] = d == 8'h00;
            dst = {1'b0, ~w[13] & w[7]};
          end
          14'b00_1101_????_????: begin
            d = {b[6:0], f_r[0]};
            f_r[0] = b[7];
            dst = {1'b0, w[7]};
          end
          14'b00_0000_1???_????: begin
            d = a_r;
            dst = 2'h1;
          end
          14'b11_01??_????_????: begin
            a_r = w[7:0];
            p_r = i_stack_top;
          end
          14'h0008: p_r = i_stack_top;
          14'h0009: begin
            p_r = i_stack_top;
            f_r[3] = 1'b1;
          end
          14'h0062: o_r = a_r;
          default: ;
        endcase
        if (dst == 2'h0) a_r = d;
        if (dst == 2'h1) fm[w[6:0]] <= d;
        q.push_back({a_r, f_r, p_r, o_r, dst == 2'h1,
          d & {8{dst == 2'h1}}, w[13:10] == 4'hD || w[13:1] == 13'h0004});
      end
    end
  end
  // Oldest note against what the outputs show
  always @(negedge i_ref_clk) if (took) chk({acc, global_irq_enable, z, dc, c, pc, opt,
    fwr, fwd & {8{fwr}}, pop}, q.pop_front());
  initial begin
    for (k = 0; k < 128; k = k + 1) fm[k] = k * 37;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    bus(2'h0, 8'hA3, 1'b1);
    bus(2'h3, 8'h10, 1'b1);
    bus(2'h1, 8'h06, 1'b1);
    bus(2'h2, 8'h5A, 1'b1);
    bus(2'h2, 8'h5A, 1'b0);
    for (p = 0; p < 6; p = p + 1) begin
      // Second reset mid-run
      if (p == 3) begin
        i_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
      end
      for (k = 0; k < 40; k = k + 1) begin
        rnd = nx(rnd);
        e = KT[(rnd[31:16] % 11) * 24 +: 24];
        i_pm.mem[k] = e[23:10] | (rnd[13:0] & {4'h0, e[9:0]});
      end
      i_pm.n = 7'd40;
      slow <= p[0];
      start <= 1'b1;
      @(posedge i_ref_clk);
      start <= 1'b0;
      @(posedge i_ref_clk);
      for (k = 0; k < 300 && !done; k = k + 1) @(posedge i_ref_clk);
      // A hang counts once and ends the loop
      if (!done) begin
        errors = errors + 1;
        p = 6;
      end
      repeat (3) @(posedge i_ref_clk);
      bus(2'h0, a_r, 1'b0);
      bus(2'h1, {4'h0, f_r}, 1'b0);
      bus(2'h2, o_r, 1'b0);
      bus(2'h3, p_r[7:0], 1'b0);
      $display("test %0d done", p);
    end
    test_done;
  end
endmodule
